// [hw/enc_pos.sv]
// encoder position counter with avalon-mm registers and sample fifo
`timescale 1ns/1ps
`include "enc_pos_consts.svh"

// ----------------------------------------------------------------------------
// sample fifo
// ----------------------------------------------------------------------------
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] used_reg;
    logic push;
    logic pop;

    // handshakes on each side; full and empty come from the fill level,
    // which is one bit wider than the pointers so that a full fifo and
    // an empty one never look alike when the pointers meet
    assign in_ready_out = (used_reg != (AW+1)'(DEPTH));
    assign out_valid_out = (used_reg != '0);
    assign out_data_out = mem[rd_ptr_reg];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // storage has no reset so it can map to plain ram
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_in;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            used_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                used_reg <= used_reg + 1'b1;
            end else if (pop && !push) begin
                used_reg <= used_reg - 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------------------------------------------
// position counter top
// ----------------------------------------------------------------------------
module enc_pos (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic chan_a_in,
    input wire logic chan_b_in,
    input wire logic chan_z_in,
    input wire logic gate_in,
    output logic [31:0] dma_data_out,
    output logic dma_valid_out,
    input wire logic dma_ready_in,
    output logic overrun_out
);
    // bus handshake states, one-hot
    typedef enum logic [1:0] {
        bus_idle = 2'b01,
        bus_ack = 2'b10
    } bus_state_t;

    enc_pos_pkg::ctrl_t ctrl_reg;
    logic [31:0] reload_reg;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    enc_pos_pkg::enc_chan_t sync1_reg;
    enc_pos_pkg::enc_chan_t sync2_reg;
    enc_pos_pkg::enc_chan_t prev_reg;
    logic gate_s1_reg;
    logic gate_s2_reg;
    logic gate_prev_reg;
    logic overrun_reg;
    bus_state_t bus_reg;
    logic step_up;
    logic step_dn;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic [1:0] phase_now;
    logic reload_hit;
    logic sample_edge;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [31:0] fifo_out_data;
    logic dma_take;
    logic bus_wr;
    logic bus_rd;

    // apply byte enables to a register word; both writable registers use it
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    // encoder pins are asynchronous; the first stage feeds only the second.
    // all stages reset to the idle low level, so no false edge follows reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
        end else begin
            sync1_reg <= '{a: chan_a_in, b: chan_b_in, z: chan_z_in};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg; // history for edge detection
        end
    end

    // the sample clock is just as asynchronous and gets its own two stages
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gate_s1_reg <= 1'b0;
            gate_s2_reg <= 1'b0;
            gate_prev_reg <= 1'b0;
        end else begin
            gate_s1_reg <= gate_in;
            gate_s2_reg <= gate_s1_reg;
            gate_prev_reg <= gate_s2_reg;
        end
    end

    // ------------------------------------------------------------------------
    // edge and direction decode
    // ------------------------------------------------------------------------
    // a pin edge reaches the count on the third clock edge after it
    assign a_rise = sync2_reg.a && !prev_reg.a;
    assign a_fall = !sync2_reg.a && prev_reg.a;
    assign b_rise = sync2_reg.b && !prev_reg.b;
    assign b_fall = !sync2_reg.b && prev_reg.b;
    // phase is {b, a}, the order of the reload phase field
    assign phase_now = {sync2_reg.b, sync2_reg.a};

    // a leads b when a moves to differ from b, or b moves to equal a;
    // simultaneous rises in two-pulse mode cancel out
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        case (ctrl_reg.mode)
            enc_pos_pkg::quad_single_edge_mode: begin
                step_up = a_rise && !sync2_reg.b;
                step_dn = a_fall && !sync2_reg.b;
            end
            enc_pos_pkg::quad_double_edge_mode: begin
                step_up = (a_rise && !sync2_reg.b) || (a_fall && sync2_reg.b);
                step_dn = (a_fall && !sync2_reg.b) || (a_rise && sync2_reg.b);
            end
            enc_pos_pkg::quad_quadruple_edge_mode: begin
                step_up = (a_rise && !sync2_reg.b) || (a_fall && sync2_reg.b) ||
                          (b_rise && sync2_reg.a) || (b_fall && !sync2_reg.a);
                step_dn = (a_fall && !sync2_reg.b) || (a_rise && sync2_reg.b) ||
                          (b_rise && !sync2_reg.a) || (b_fall && sync2_reg.a);
            end
            enc_pos_pkg::two_pulse_mode: begin
                step_up = a_rise && !b_rise;
                step_dn = b_rise && !a_rise;
            end
            default: begin
                step_up = 1'b0;
                step_dn = 1'b0;
            end
        endcase
    end

    // reload only matters for quadrature modes, where phases exist;
    // the index is a level: while it stays high in the chosen phase
    // the count is held at the reload value
    assign reload_hit = ctrl_reg.idx_en && sync2_reg.z &&
                        (ctrl_reg.mode != enc_pos_pkg::two_pulse_mode) &&
                        (phase_now == ctrl_reg.phase);

    // ------------------------------------------------------------------------
    // position counter
    // ------------------------------------------------------------------------
    // the step is taken in the cycle the phase is entered and the reload in the
    // next, so the count shows the step for one cycle before being reloaded;
    // plain 32-bit add and subtract wrap at both ends
    always_comb begin
        count_next = count_reg;
        if (!ctrl_reg.arm) begin
            count_next = count_reg;
        end else if (step_up) begin
            count_next = count_reg + 32'h0000_0001;
        end else if (step_dn) begin
            count_next = count_reg - 32'h0000_0001;
        end else if (reload_hit) begin
            count_next = reload_reg;
        end
    end

    // arming from disarmed clears the count so samples are cumulative from arm
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= 32'h0000_0000;
        end else if (bus_wr && avs_address_in == `ADDR_CTRL && avs_byteenable_in[0] &&
                     avs_writedata_in[`CTRL_ARM] && !ctrl_reg.arm) begin
            count_reg <= 32'h0000_0000;
        end else begin
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------------------
    // sample clock and buffer
    // ------------------------------------------------------------------------
    // the edge is judged on synchronised gate levels, only while armed
    assign sample_edge = ctrl_reg.arm && ctrl_reg.buf_en &&
                         (ctrl_reg.fall_edge ? (gate_prev_reg && !gate_s2_reg)
                                             : (!gate_prev_reg && gate_s2_reg));

    // the sample copies the count and leaves it running
    sample_fifo #(
        .WIDTH(`COUNT_W),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_valid_in(sample_edge),
        .in_ready_out(fifo_in_ready),
        .in_data_in(count_reg),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(dma_take),
        .out_data_out(fifo_out_data)
    );

    // output stage register keeps the dma outputs straight from flops;
    // a word leaves the fifo only when the stage is empty or emptying,
    // so a stalled consumer backs up the fifo instead of losing data
    assign dma_take = fifo_out_valid && (!dma_valid_out || dma_ready_in);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dma_valid_out <= 1'b0;
            dma_data_out <= 32'h0000_0000;
        end else if (dma_take) begin
            dma_valid_out <= 1'b1;
            dma_data_out <= fifo_out_data;
        end else if (dma_ready_in) begin
            dma_valid_out <= 1'b0;
        end
    end

    // a sample with no room is lost; sticky flag, set wins over clear,
    // so a loss between two polls is never missed
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            overrun_reg <= 1'b0;
        end else if (sample_edge && !fifo_in_ready) begin
            overrun_reg <= 1'b1;
        end else if (bus_wr && avs_address_in == `ADDR_STATUS && avs_writedata_in[0]) begin
            overrun_reg <= 1'b0;
        end
    end
    assign overrun_out = overrun_reg;

    // ------------------------------------------------------------------------
    // avalon-mm slave
    // ------------------------------------------------------------------------
    // one wait cycle per access; the answer comes on the second edge.
    // read data is loaded at the first edge so it stands when waitrequest
    // is seen low; a write lands only at that second edge
    assign bus_wr = avs_write_in && bus_reg == bus_ack;
    assign bus_rd = avs_read_in && bus_reg == bus_idle;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_reg <= bus_idle;
            avs_waitrequest_out <= 1'b1;
        end else begin
            case (bus_reg)
                bus_idle: begin
                    if (avs_read_in || avs_write_in) begin
                        bus_reg <= bus_ack;
                        avs_waitrequest_out <= 1'b0;
                    end
                end
                bus_ack: begin
                    bus_reg <= bus_idle;
                    avs_waitrequest_out <= 1'b1;
                end
                default: begin
                    bus_reg <= bus_idle;
                    avs_waitrequest_out <= 1'b1;
                end
            endcase
        end
    end

    // control register; only its low byte exists, the rest reads as zero
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_reg <= 8'(`CTRL_RESET);
        end else if (bus_wr && avs_address_in == `ADDR_CTRL) begin
            ctrl_reg <= 8'(merge_bytes({24'h00_0000, ctrl_reg}, avs_writedata_in,
                                       avs_byteenable_in));
        end
    end

    // reload value; a change takes effect at the next index match
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reload_reg <= `RELOAD_RESET;
        end else if (bus_wr && avs_address_in == `ADDR_RELOAD) begin
            reload_reg <= merge_bytes(reload_reg, avs_writedata_in, avs_byteenable_in);
        end
    end

    // register reads; unmapped addresses read as zero. the count is copied
    // once per access, so software sees one consistent value
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (bus_rd) begin
            case (avs_address_in)
                `ADDR_CTRL: avs_readdata_out <= {24'h00_0000, ctrl_reg};
                `ADDR_RELOAD: avs_readdata_out <= reload_reg;
                `ADDR_COUNT: avs_readdata_out <= count_reg;
                `ADDR_STATUS: avs_readdata_out <= {29'h0000_0000, fifo_out_valid,
                                                   !fifo_in_ready, overrun_reg};
                `ADDR_SAMPLE: avs_readdata_out <= dma_data_out;
                default: avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// [hw/enc_pos_consts.svh]
// constants for the encoder position counter: offsets, fields, reset values
// ----------------------------------------------------------------------------
// How it works
// - counting starts only after software sets the arm bit.
// - in single-edge mode the count goes up when A leads B and down when B leads A.
// - in single-edge mode the up step is taken on A rising and the down step on A falling.
// - in double-edge mode both edges of A count, two steps per cycle, direction by lead.
// - in quadruple-edge mode every edge of A and B counts, four steps per cycle.
// - with index reload on, the count is loaded with the reload value while the index is high in the chosen phase.
// - a counting edge that enters the reload phase is applied before the reload.
// - the reload is done within one clock after the phase and index are both true.
// - after a reload counting goes on from the loaded value in the same mode.
// - in two-pulse mode A rising counts up and B rising counts down.
// - the count can be read on demand or sampled into a buffer by a sample clock.
// - in buffered mode each active sample clock edge captures the count for the DMA path; the code loses an edge that finds the fifo full and sets overrun.
// - sampling never clears the count; samples are cumulative since arming.
// - the sample clock comes on the gate input with a selectable active edge.
// ----------------------------------------------------------------------------
`ifndef ENC_POS_CONSTS_SVH
`define ENC_POS_CONSTS_SVH
`define ADDR_CTRL 4'h0
`define ADDR_RELOAD 4'h1
`define ADDR_COUNT 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_SAMPLE 4'h4
`define CTRL_ARM 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_IDX_EN 3
`define CTRL_PHASE_LO 4
`define CTRL_PHASE_HI 5
`define CTRL_BUF_EN 6
`define CTRL_FALL_EDGE 7
`define CTRL_RESET 32'h0000_0000
`define RELOAD_RESET 32'h0000_0000
`define FIFO_DEPTH 4
`define COUNT_W 32
`endif

// [hw/enc_pos_pkg.sv]
// types shared by the encoder position counter
package enc_pos_pkg;
    typedef enum logic [1:0] {
        quad_single_edge_mode = 2'h0,
        quad_double_edge_mode = 2'h1,
        quad_quadruple_edge_mode = 2'h2,
        two_pulse_mode = 2'h3
    } enc_mode_t;
    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } enc_chan_t;
    typedef struct packed {
        logic fall_edge;
        logic buf_en;
        logic [1:0] phase;
        logic idx_en;
        enc_mode_t mode;
        logic arm;
    } ctrl_t;
endpackage

// [verif/enc_model.sv]
// encoder model: quadrature quarter steps, two-pulse pulses and index level
`timescale 1ns/1ps
module enc_model (
    input wire logic clk_in,
    output logic chan_a_out,
    output logic chan_b_out,
    output logic chan_z_out
);
    // ------------------------------------------------
    // encoder lines
    // ------------------------------------------------
    // lines idle low; every phase lasts at least 8 clocks so the synchroniser sees it
    initial begin
        chan_a_out = 1'b0;
        chan_b_out = 1'b0;
        chan_z_out = 1'b0;
    end
    // forward walks ab 00-10-11-01, reverse the other way round
    task automatic step(input logic fwd, input logic z);
        @(posedge clk_in);
        chan_z_out <= z; // index rides along with the phase it enters
        if ((chan_a_out == chan_b_out) == fwd) begin
            chan_a_out <= !chan_a_out;
        end else begin
            chan_b_out <= !chan_b_out;
        end
        repeat (8) @(posedge clk_in);
    endtask
    // one pulse on a (up) or b (down) in two-pulse use
    task automatic pulse(input logic on_b);
        @(posedge clk_in);
        if (on_b) begin
            chan_b_out <= 1'b1;
        end else begin
            chan_a_out <= 1'b1;
        end
        repeat (8) @(posedge clk_in);
        chan_a_out <= 1'b0;
        chan_b_out <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask
endmodule

// [verif/enc_pos_props.sv]
// port checker for the encoder position counter
`timescale 1ns/1ps
module enc_pos_props (
    input wire logic clk_in, rst_in, avs_read_in, avs_write_in,
    input wire logic [3:0] avs_address_in, avs_byteenable_in,
    input wire logic [31:0] avs_writedata_in, avs_readdata_out, dma_data_out,
    input wire logic avs_waitrequest_out, chan_a_in, chan_b_in, chan_z_in, gate_in,
    input wire logic dma_valid_out, dma_ready_in, overrun_out
);
    // ------------------------------------------------
    // helper logic
    // ------------------------------------------------
    logic [31:0] reload_shadow_reg;
    logic rd_done;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // a read is answered at the edge where waitrequest is seen low
    assign rd_done = avs_read_in && !avs_waitrequest_out;
    // own copy of the reload value, merged byte by byte
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reload_shadow_reg <= 32'h0000_0000;
        end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h1) begin
            for (int i = 0; i < 4; i++) begin
                if (avs_byteenable_in[i]) begin
                    reload_shadow_reg[8*i +: 8] <= avs_writedata_in[8*i +: 8];
                end
            end
        end
    end
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    answer_next_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("bus request not answered next cycle");
    wait_cause_a: assert property ($fell(avs_waitrequest_out)
        |-> $past(avs_read_in || avs_write_in)) else $error("answer without request");
    unmapped_zero_a: assert property (rd_done && avs_address_in > 4'h4
        |-> avs_readdata_out == 32'h0000_0000) else $error("unmapped read not zero");
    reload_back_a: assert property (rd_done && avs_address_in == 4'h1
        |-> avs_readdata_out == reload_shadow_reg) else $error("reload read-back wrong");
    dma_hold_a: assert property (dma_valid_out && !dma_ready_in
        |=> dma_valid_out && $stable(dma_data_out)) else $error("dma word not held");
    overrun_sticky_a: assert property (overrun_out
        && !(avs_write_in && avs_address_in == 4'h3 && avs_writedata_in[0])
        |=> overrun_out) else $error("overrun dropped without clear");
    status_flag_a: assert property (rd_done && avs_address_in == 4'h3
        |-> avs_readdata_out[0] == $past(overrun_out)) else $error("status overrun wrong");
endmodule

bind enc_pos enc_pos_props i_props (.*);

// [verif/test_enc_pos.sv]
// self-checking bench for the encoder position counter
`timescale 1ns/1ps
`include "enc_pos_consts.svh"
module test_enc_pos;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [31:0] avs_readdata_out, dma_data_out;
    logic avs_waitrequest_out, chan_a_in, chan_b_in, chan_z_in, dma_valid_out, overrun_out;
    logic gate_in = 1'b0;
    logic dma_ready_in = 1'b0;
    int fails = 0;
    int n_tests = 0;
    enc_pos_pkg::ctrl_t c;
    // ------------------------------------------------
    // clock, design and encoder
    // ------------------------------------------------
    always #5 clk_in = ~clk_in;
    enc_pos i_dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .chan_a_in(chan_a_in), .chan_b_in(chan_b_in), .chan_z_in(chan_z_in),
        .gate_in(gate_in), .dma_data_out(dma_data_out), .dma_valid_out(dma_valid_out),
        .dma_ready_in(dma_ready_in), .overrun_out(overrun_out));
    enc_model i_enc (.clk_in(clk_in), .chan_a_out(chan_a_in), .chan_b_out(chan_b_in),
        .chan_z_out(chan_z_in));
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // request held until waitrequest is seen low; a hung slave ends the run
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 100);
        if (avs_waitrequest_out !== 1'b0) begin
            fails++;
            $display("Error at %0t ns: bus wait timed out", $time);
            close_out();
        end
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, e);
    endtask
    // drop arm then raise it, since only a fresh arm clears the count
    task automatic arm;
        c.arm = 1'b0;
        wr(`ADDR_CTRL, 32'(c));
        c.arm = 1'b1;
        wr(`ADDR_CTRL, 32'(c));
    endtask
    task automatic steps(input int n, input logic fwd);
        repeat (n) i_enc.step(fwd, 1'b0);
    endtask
    // gate high, one forward step, gate low: the edge choice decides the sample
    task automatic gstep;
        @(posedge clk_in);
        gate_in <= 1'b1;
        i_enc.step(1'b1, 1'b0);
        gate_in <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask
    task automatic take(input logic [31:0] e);
        int n;
        n = 0;
        while (dma_valid_out !== 1'b1 && n < 50) begin
            @(posedge clk_in);
            n++;
        end
        if (dma_valid_out !== 1'b1) begin
            fails++;
            $display("Error at %0t ns: dma wait timed out", $time);
            close_out();
        end
        check(dma_data_out, e);
        dma_ready_in <= 1'b1;
        @(posedge clk_in);
        dma_ready_in <= 1'b0;
        @(posedge clk_in);
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_regs;
        rd(`ADDR_CTRL, `CTRL_RESET);
        steps(4, 1'b1);
        rd(`ADDR_COUNT, 32'h0000_0000);
        wr(`ADDR_RELOAD, 32'h1234_5678);
        rd(`ADDR_RELOAD, 32'h1234_5678);
        wr(`ADDR_COUNT, 32'h0000_0055);
        rd(`ADDR_COUNT, 32'h0000_0000);
        rd(4'h9, 32'h0000_0000);
        $display("test regs done");
    endtask
    // 4 forward, 2 back, 6 back: counts per mode follow the edges used
    task automatic t_quad;
        int k[3] = '{1, 2, 4};
        int h[3] = '{1, 1, 2};
        for (int m = 0; m < 3; m++) begin
            c = '0;
            c.mode = enc_pos_pkg::enc_mode_t'(m);
            arm();
            steps(4, 1'b1);
            rd(`ADDR_COUNT, 32'(k[m]));
            steps(2, 1'b0);
            rd(`ADDR_COUNT, 32'(h[m]));
            steps(6, 1'b0);
            rd(`ADDR_COUNT, -32'(k[m]));
        end
        $display("test quadrature done");
    endtask
    task automatic t_pulse;
        c = '0;
        c.mode = enc_pos_pkg::two_pulse_mode;
        arm();
        repeat (3) i_enc.pulse(1'b0);
        i_enc.pulse(1'b1);
        rd(`ADDR_COUNT, 32'h0000_0002);
        $display("test two-pulse done");
    endtask
    // index high in a foreign phase must not reload; in phase 00 it must
    task automatic t_index;
        c = '0;
        c.mode = enc_pos_pkg::quad_quadruple_edge_mode;
        c.idx_en = 1'b1;
        c.phase = 2'b00;
        arm();
        i_enc.step(1'b1, 1'b1);
        rd(`ADDR_COUNT, 32'h0000_0001);
        steps(2, 1'b1);
        i_enc.step(1'b1, 1'b1);
        rd(`ADDR_COUNT, 32'h1234_5678);
        steps(1, 1'b1);
        rd(`ADDR_COUNT, 32'h1234_5679);
        $display("test index done");
    endtask
    // dma stalled while six samples arrive, so the fifo must refuse
    task automatic t_buffer;
        c = '0;
        c.mode = enc_pos_pkg::quad_quadruple_edge_mode;
        c.buf_en = 1'b1;
        arm();
        repeat (6) gstep();
        check(overrun_out, 1'b1);
        rd(`ADDR_STATUS, 32'h0000_0007);
        for (int i = 0; i < 4; i++) take(32'(i));
        dma_ready_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        dma_ready_in <= 1'b0;
        wr(`ADDR_STATUS, 32'h0000_0001);
        rd(`ADDR_STATUS, 32'h0000_0000);
        c.fall_edge = 1'b1;
        arm();
        gstep();
        take(32'h0000_0001);
        $display("test buffer done");
    endtask
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_quad();
        t_pulse();
        t_index();
        t_buffer();
        close_out();
    end
endmodule
